// ### common/mlpr_pkg.sv
// Purpose: Shared constants and types for the multilevel pipeline register.
// Assumes: One clock at 100 MHz, synchronous active-high reset.
// Notes:   Offsets are word byte addresses on a 32-bit classic Wishbone bus.
package mlpr_pkg;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned ADDR_W = 4;

   // Register byte offsets.
   localparam logic [ADDR_W-1:0] CTRL_OFS   = 4'h0;
   localparam logic [ADDR_W-1:0] DATA_OFS   = 4'h4;
   localparam logic [ADDR_W-1:0] OUT_OFS    = 4'h8;
   localparam logic [ADDR_W-1:0] STAGE_OFS  = 4'hc;

   // Control register fields.
   localparam int unsigned CTRL_INSTR_LSB = 0;
   localparam int unsigned CTRL_SEL_LSB   = 2;
   localparam int unsigned CTRL_OE_N_BIT  = 4;
   localparam logic [4:0]  CTRL_RST_VAL   = 5'h13;

   // Instruction codes.
   localparam logic [1:0] INSTR_SHIFT4 = 2'h0;
   localparam logic [1:0] INSTR_LOAD_B = 2'h1;
   localparam logic [1:0] INSTR_LOAD_A = 2'h2;
   localparam logic [1:0] INSTR_HOLD   = 2'h3;

   // Output select codes.
   localparam logic [1:0] SEL_B2 = 2'h0;
   localparam logic [1:0] SEL_B1 = 2'h1;
   localparam logic [1:0] SEL_A2 = 2'h2;
   localparam logic [1:0] SEL_A1 = 2'h3;

   typedef struct packed {
      logic [BYTE_W-1:0] pair_a_first_stage;
      logic [BYTE_W-1:0] pair_a_second_stage;
      logic [BYTE_W-1:0] pair_b_first_stage;
      logic [BYTE_W-1:0] pair_b_second_stage;
   } stages_t;

   typedef struct packed {
      logic              cyc;
      logic              stb;
      logic              we;
      logic [3:0]        sel;
      logic [ADDR_W-1:0] adr;
      logic [31:0]       dat;
   } wb_req_t;
endpackage : mlpr_pkg

// ### hw/multilevel_pipeline_register.sv
// Purpose: Multilevel pipeline register behind a classic Wishbone slave.
// Assumes: Synchronous active-high reset resets the bus logic, the control
//          register and the output pin registers; stage contents are not reset.
// Notes:   A write to the data register steps the pipeline once.
//
// Overview of operation
// - Four byte registers, one byte input, readable.
// - Instruction picks four-stage or two-pair mode.
// - Shift variant moves first stage into second.
// - Overwrite variant replaces only the first stage.
// - Code zero shifts all four stages.
// - Code zero also loads input into first A.
// - Code three holds all four registers.
// - All changes occur on rising clock edge.
// - Two-bit select muxes one register to output.
// - Output driven when enable low, floats high.
// - Output enable never affects register updates.
// - Select 0=B2, 1=B1, 2=A2, 3=A1.
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module multilevel_pipeline_register #(
   parameter bit SHIFT_PAIR = 1'b1
) (
   input  wire logic        clk_i,         // 100 MHz clock.
   input  wire logic        rst_i,         // Synchronous reset, high.
   input  wire logic        wb_cyc_i,      // Wishbone cycle.
   input  wire logic        wb_stb_i,      // Wishbone strobe.
   input  wire logic        wb_we_i,       // Wishbone write enable.
   input  wire logic [3:0]  wb_sel_i,      // Wishbone byte selects.
   input  wire logic [3:0]  wb_adr_i,      // Wishbone byte address.
   input  wire logic [31:0] wb_dat_i,      // Wishbone write data.
   output logic [31:0]      wb_dat_o,      // Wishbone read data.
   output logic             wb_ack_o,      // Wishbone acknowledge.
   output logic             wb_err_o,      // Unmapped address answer.
   output logic [7:0]       output_byte_o, // Selected stage byte.
   output logic [7:0]       output_byte_oe_n_o // Low while driving.
);
   ////////////////////////////////////////////////////////////////////////
   mlpr_pkg::wb_req_t req;
   mlpr_pkg::stages_t stages;
   logic [4:0]        ctrl_r;
   logic [7:0]        mux_byte;
   logic [31:0]       rd_nxt;
   logic              hit;
   logic              mapped;
   logic              step;
   logic              ctrl_wr;

   assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                  sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};
   assign hit = req.cyc && req.stb && !wb_ack_o && !wb_err_o;
   assign mapped = (req.adr == mlpr_pkg::CTRL_OFS) ||
                   (req.adr == mlpr_pkg::DATA_OFS) ||
                   (req.adr == mlpr_pkg::OUT_OFS)  ||
                   (req.adr == mlpr_pkg::STAGE_OFS);
   assign step = hit && req.we && req.sel[0] &&
                 (req.adr == mlpr_pkg::DATA_OFS);
   assign ctrl_wr = hit && req.we && req.sel[0] &&
                    (req.adr == mlpr_pkg::CTRL_OFS);

   ////////////////////////////////////////////////////////////////////////
   // Control register: instruction, output select, output enable.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= mlpr_pkg::CTRL_RST_VAL;
      end else if (ctrl_wr) begin
         ctrl_r <= req.dat[4:0];
      end
   end

   stage_core #(.SHIFT_PAIR(SHIFT_PAIR)) u_core (
      .clk_i        (clk_i),
      .step_i       (step),
      .instr_i      (ctrl_r[mlpr_pkg::CTRL_INSTR_LSB +: 2]),
      .input_byte_i (req.dat[7:0]),
      .stages_o     (stages)
   );

   out_mux u_mux (
      .stages_i (stages),
      .sel_i    (ctrl_r[mlpr_pkg::CTRL_SEL_LSB +: 2]),
      .byte_o   (mux_byte)
   );

   ////////////////////////////////////////////////////////////////////////
   // Output pins follow the mux; enable touches only the drivers.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         output_byte_o      <= 8'h00;
         output_byte_oe_n_o <= 8'hff;
      end else begin
         output_byte_o      <= mux_byte;
         output_byte_oe_n_o <= {8{ctrl_r[mlpr_pkg::CTRL_OE_N_BIT]}};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (req.adr)
         mlpr_pkg::CTRL_OFS:  rd_nxt = {27'h0, ctrl_r};
         mlpr_pkg::OUT_OFS:   rd_nxt = {24'h0, mux_byte};
         mlpr_pkg::STAGE_OFS: rd_nxt = stages;
         default:             rd_nxt = 32'h0000_0000;
      endcase
   end

   // Single-cycle answer; ack drops the cycle after it is given.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= hit && mapped;
         wb_err_o <= hit && !mapped;
         wb_dat_o <= (hit && !req.we) ? rd_nxt : 32'h0000_0000;
      end
   end
endmodule // multilevel_pipeline_register
`default_nettype wire

// ### hw/out_mux.sv
// Purpose: Chooses one stage for the byte output.
// Assumes: Purely combinational.
// Notes:   Encoding follows the register select table.
`timescale 1ns/10ps
`default_nettype none
module out_mux (
   input  wire mlpr_pkg::stages_t           stages_i, // Stage contents.
   input  wire logic [1:0]                  sel_i,    // Output select.
   output logic [mlpr_pkg::BYTE_W-1:0]      byte_o    // Selected byte.
);
   always_comb begin
      case (sel_i)
         mlpr_pkg::SEL_B2: byte_o = stages_i.pair_b_second_stage;
         mlpr_pkg::SEL_B1: byte_o = stages_i.pair_b_first_stage;
         mlpr_pkg::SEL_A2: byte_o = stages_i.pair_a_second_stage;
         mlpr_pkg::SEL_A1: byte_o = stages_i.pair_a_first_stage;
         default:          byte_o = stages_i.pair_a_first_stage;
      endcase
   end
endmodule // out_mux
`default_nettype wire

// ### hw/stage_core.sv
// Purpose: Four byte stages, two pairs, stepped by a 2-bit instruction.
// Assumes: Loads happen only on the rising clock edge with step_i high.
// Notes:   SHIFT_PAIR selects pair shifting (1) or overwriting (0).
`timescale 1ns/10ps
`default_nettype none
module stage_core #(
   parameter bit SHIFT_PAIR = 1'b1
) (
   input  wire logic                       clk_i,     // System clock.
   input  wire logic                       step_i,    // Apply instruction.
   input  wire logic [1:0]                 instr_i,   // Instruction code.
   input  wire logic [mlpr_pkg::BYTE_W-1:0] input_byte_i, // Data in.
   output var mlpr_pkg::stages_t           stages_o   // Stage contents.
);
   mlpr_pkg::stages_t st_r;

   // Stage contents have no reset; they are undefined until loaded.
   always_ff @(posedge clk_i) begin
      if (step_i) begin
         case (instr_i)
            mlpr_pkg::INSTR_SHIFT4: begin
               st_r.pair_a_first_stage  <= input_byte_i;
               st_r.pair_a_second_stage <= st_r.pair_a_first_stage;
               st_r.pair_b_first_stage  <= st_r.pair_a_second_stage;
               st_r.pair_b_second_stage <= st_r.pair_b_first_stage;
            end
            mlpr_pkg::INSTR_LOAD_B: begin
               st_r.pair_b_first_stage <= input_byte_i;
               if (SHIFT_PAIR) begin
                  st_r.pair_b_second_stage <= st_r.pair_b_first_stage;
               end // Else the second stage keeps its value.
            end
            mlpr_pkg::INSTR_LOAD_A: begin
               st_r.pair_a_first_stage <= input_byte_i;
               if (SHIFT_PAIR) begin
                  st_r.pair_a_second_stage <= st_r.pair_a_first_stage;
               end // Else the second stage keeps its value.
            end
            mlpr_pkg::INSTR_HOLD: begin
               st_r <= st_r;
            end
            default: begin
               st_r <= st_r;
            end
         endcase
      end
   end

   assign stages_o = st_r;
endmodule // stage_core
`default_nettype wire

// ### testbench/mlpr_props.sv
// Purpose: Bus and pin properties of the pipeline register.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/10ps
`default_nettype none
module mlpr_props (
   input wire logic        clk_i,              // Clock.
   input wire logic        rst_i,              // Reset.
   input wire logic        wb_cyc_i,           // Cycle.
   input wire logic        wb_stb_i,           // Strobe.
   input wire logic        wb_we_i,            // Write.
   input wire logic [3:0]  wb_sel_i,           // Byte selects.
   input wire logic [3:0]  wb_adr_i,           // Address.
   input wire logic [31:0] wb_dat_i,           // Write data.
   input wire logic [31:0] wb_dat_o,           // Read data.
   input wire logic        wb_ack_o,           // Acknowledge.
   input wire logic        wb_err_o,           // Error.
   input wire logic [7:0]  output_byte_o,      // Pin byte.
   input wire logic [7:0]  output_byte_oe_n_o  // Pin enables.
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic req;
   logic wr_ctrl;
   logic wr_data;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign wr_ctrl = req && wb_we_i && wb_sel_i[0] && wb_adr_i == 4'h0;
   assign wr_data = req && wb_we_i && wb_adr_i == 4'h4;
   a_ack_one_cycle:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   a_answer_next:
      assert property (req |=> wb_ack_o || wb_err_o) else $error("no answer");
   a_err_unmapped:
      assert property (req && wb_adr_i[1:0] != 2'h0 |=> wb_err_o && !wb_ack_o)
      else $error("unmapped not refused");
   a_dat_idle_zero:
      assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat idle");
   a_oe_from_ctrl:
      assert property (wr_ctrl |=> ##1
         output_byte_oe_n_o == {8{$past(wb_dat_i[4], 2)}}) else $error("oe");
   a_oe_data_kept:
      assert property (wr_data |=> ##1 $stable(output_byte_oe_n_o))
      else $error("oe moved by data");
   a_oe_uniform:
      assert property (output_byte_oe_n_o == 8'h00 ||
         output_byte_oe_n_o == 8'hff) else $error("oe mixed");
   a_ack_err_excl:
      assert property (!(wb_ack_o && wb_err_o)) else $error("ack and err");
endmodule // mlpr_props
bind multilevel_pipeline_register mlpr_props u_mlpr_props (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .wb_err_o(wb_err_o), .output_byte_o(output_byte_o),
   .output_byte_oe_n_o(output_byte_oe_n_o));
`default_nettype wire

// ### testbench/out_pads.sv
// Purpose: Pull-up pad model on the byte output pins.
// Assumes: Per-bit enable, low while driving.
// Notes:   Released bits read back high.
`timescale 1ns/10ps
`default_nettype none
module out_pads (
   input  wire logic [7:0] byte_i, // Driven byte.
   input  wire logic [7:0] oe_n_i, // Enables, low drives.
   output logic [7:0]      pad_o   // Wire level.
);
   assign pad_o = byte_i | oe_n_i;
endmodule // out_pads
`default_nettype wire

// ### testbench/tb_top.sv
// Purpose: Bus tests of both pipeline register variants.
// Assumes: Both variants share one bus; every read checks each.
// Notes:   Pins are watched through the pull-up pad model.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc = 1'b0;
   logic        wb_stb = 1'b0;
   logic        wb_we = 1'b0;
   logic [3:0]  wb_adr = 4'h0;
   logic [31:0] wb_wdat = 32'h0;
   logic [31:0] rd_s, rd_o;
   logic        ack_s, ack_o, err_s, err_o;
   logic [7:0]  byte_s, oe_s, pad;
   logic [7:0]  byte_w, oe_w, pad_w;
   logic [31:0] dv [4] = '{32'h11, 32'h22, 32'h33, 32'h44};
   int          err_total = 0;
   int          samples_checked = 0;
   multilevel_pipeline_register #(.SHIFT_PAIR(1'b1))
   u_multilevel_pipeline_register (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_sel_i(4'hf),
      .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_dat_o(rd_s), .wb_ack_o(ack_s),
      .wb_err_o(err_s), .output_byte_o(byte_s), .output_byte_oe_n_o(oe_s));
   multilevel_pipeline_register #(.SHIFT_PAIR(1'b0))
   u_multilevel_pipeline_register_ow (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_sel_i(4'hf),
      .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_dat_o(rd_o), .wb_ack_o(ack_o),
      .wb_err_o(err_o), .output_byte_o(byte_w), .output_byte_oe_n_o(oe_w));
   out_pads u_out_pads (.byte_i(byte_s), .oe_n_i(oe_s), .pad_o(pad));
   out_pads u_out_pads_ow (.byte_i(byte_w), .oe_n_i(oe_w), .pad_o(pad_w));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      if (err_total == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic acc(input logic w, input logic [3:0] a,
                      input logic [31:0] d, es, eo);
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_wdat <= d;
      do @(posedge clk_i); while (ack_s !== 1'b1 && err_s !== 1'b1);
      if (!w) chk(rd_s, es);
      if (!w) chk(rd_o, eo);
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      acc(1'b1, a, d, 32'h0, 32'h0);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] es, eo);
      acc(1'b0, a, 32'h0, es, eo);
   endtask
   task automatic pin(input logic [7:0] e);
      repeat (2) @(posedge clk_i);
      #1 chk({24'h0, pad}, {24'h0, e});
      chk({24'h0, pad_w}, {24'h0, e});
   endtask
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      repeat (2000) @(posedge clk_i);
      err_total++;
      finish_test();
   end
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(4'h0, 32'h13, 32'h13);
      pin(8'hff);
      wr(4'h0, 32'h0c);
      foreach (dv[i]) wr(4'h4, dv[i]);
      rd(4'hc, 32'h44332211, 32'h44332211);
      for (int s = 0; s < 4; s++) begin
         wr(4'h0, {27'h0, 1'b0, s[1:0], 2'h3});
         pin(dv[s][7:0]);
         rd(4'h8, dv[s], dv[s]);
      end
      wr(4'h4, 32'h55);
      rd(4'hc, 32'h44332211, 32'h44332211);
      wr(4'h0, 32'h0d);
      wr(4'h4, 32'h66);
      rd(4'hc, 32'h44336622, 32'h44336611);
      wr(4'h0, 32'h0e);
      wr(4'h4, 32'h77);
      rd(4'hc, 32'h77446622, 32'h77336611);
      wr(4'h0, 32'h1c);
      pin(8'hff);
      wr(4'h4, 32'h88);
      rd(4'hc, 32'h88774466, 32'h88773366);
      rd(4'h1, 32'h0, 32'h0);
      chk({31'h0, err_s}, 32'h1);
      chk({31'h0, err_o}, 32'h1);
      // Mid-run reset: control returns to its reset value, stages survive.
      rst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(4'h0, 32'h13, 32'h13);
      pin(8'hff);
      rd(4'hc, 32'h88774466, 32'h88773366);
      finish_test();
   end
endmodule // tb_top
`default_nettype wire
